// File: design/host_port_strobe_ready.v
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.vh"

module host_port_strobe_ready (
    input wire clock,
    input wire rst_n,
    input wire clock_enable,
    input wire host_chip_select_n,
    input wire host_data_strobe_a,
    input wire host_data_strobe_b,
    input wire host_address_strobe_n,
    input wire [1:0] host_register_select,
    input wire host_read_write,
    input wire host_halfword_select,
    input wire [15:0] host_data_bus_in,
    output wire [15:0] host_data_bus_out,
    output wire host_data_bus_oe,
    output wire host_not_ready,
    output wire aux_request,
    output wire aux_write,
    output wire aux_increment,
    output wire [31:0] aux_write_data,
    input wire aux_done,
    input wire [31:0] aux_read_data,
    output wire reg_write_valid,
    output wire [1:0] reg_write_select,
    output wire [31:0] reg_write_data,
    input wire [31:0] control_read_data,
    input wire [31:0] address_read_data
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_FETCH = 4'h2;
    localparam [3:0] ST_SHOW = 4'h4;
    localparam [3:0] ST_STORE = 4'h8;

    // ****************************************************************
    // Pin synchronisation and strobe forming
    // ****************************************************************
    wire [`PIN_COUNT-1:0] pins_sync;
    wire cs_n_s;
    wire strobe_a_s;
    wire strobe_b_s;
    wire as_n_s;
    wire [1:0] sel_s;
    wire rw_s;
    wire hw_s;
    wire [15:0] data_s;

    pin_sync_agree #(
        .WIDTH(`PIN_COUNT)
    ) u_pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clock_enable(clock_enable),
        .pins({host_chip_select_n, host_data_strobe_a, host_data_strobe_b, host_address_strobe_n,
               host_register_select, host_read_write, host_halfword_select, host_data_bus_in}),
        .pins_sync(pins_sync)
    );

    assign {cs_n_s, strobe_a_s, strobe_b_s, as_n_s, sel_s, rw_s, hw_s, data_s} = pins_sync;

    wire strobe_n;
    assign strobe_n = ~(strobe_a_s ^ strobe_b_s) | cs_n_s;

    reg strobe_q;
    reg as_q;
    wire strobe_fall;
    wire strobe_rise;
    wire as_fall;
    assign strobe_fall = strobe_q & ~strobe_n;
    assign strobe_rise = ~strobe_q & strobe_n;
    assign as_fall = as_q & ~as_n_s;

    // Selects are taken at the falling strobe so that the rising edge
    // still knows what the access was even if the host moves them early.
    reg [1:0] sel_q;
    reg rw_q;
    reg hw_q;

    wire cur_data;
    wire cur_read;
    wire held_data;
    wire held_read;
    assign cur_data = (sel_s == `SEL_DATA_INC) | (sel_s == `SEL_DATA_FIXED);
    assign cur_read = (rw_s == `RW_READ);
    assign held_data = (sel_q == `SEL_DATA_INC) | (sel_q == `SEL_DATA_FIXED);
    assign held_read = (rw_q == `RW_READ);

    // ****************************************************************
    // Transfer sequencing
    // ****************************************************************
    reg [3:0] state_q;
    reg as_busy_q;
    reg [31:0] word_q;
    reg [15:0] wr_low_q;
    reg [15:0] out_q;
    reg oe_q;
    reg aux_request_q;
    reg aux_write_q;
    reg aux_increment_q;
    reg [31:0] aux_write_data_q;
    reg reg_write_valid_q;
    reg [1:0] reg_write_select_q;
    reg [31:0] reg_write_data_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= 1'b1;
            as_q <= 1'b1;
            sel_q <= `SEL_CONTROL;
            rw_q <= `RW_READ;
            hw_q <= 1'b0;
            state_q <= ST_IDLE;
            as_busy_q <= 1'b0;
            word_q <= {`WORD_WIDTH{1'b0}};
            wr_low_q <= {`HALF_WIDTH{1'b0}};
            out_q <= {`HALF_WIDTH{1'b0}};
            oe_q <= 1'b0;
            aux_request_q <= 1'b0;
            aux_write_q <= 1'b0;
            aux_increment_q <= 1'b0;
            aux_write_data_q <= {`WORD_WIDTH{1'b0}};
            reg_write_valid_q <= 1'b0;
            reg_write_select_q <= `SEL_CONTROL;
            reg_write_data_q <= {`WORD_WIDTH{1'b0}};
        end else if (clock_enable) begin
            strobe_q <= strobe_n;
            as_q <= as_n_s;
            aux_request_q <= 1'b0;
            reg_write_valid_q <= 1'b0;
            if (as_fall) begin
                as_busy_q <= 1'b1;
            end else if (strobe_fall) begin
                as_busy_q <= 1'b0;
            end
            if (strobe_fall) begin
                sel_q <= sel_s;
                rw_q <= rw_s;
                hw_q <= hw_s;
                oe_q <= cur_read;
                if (cur_read && (sel_s == `SEL_CONTROL)) begin
                    out_q <= hw_s ? control_read_data[`HIGH_HALF] : control_read_data[`LOW_HALF];
                end else if (cur_read && (sel_s == `SEL_ADDRESS)) begin
                    out_q <= hw_s ? address_read_data[`HIGH_HALF] : address_read_data[`LOW_HALF];
                end
            end else if (strobe_rise) begin
                oe_q <= 1'b0;
                if (!held_read && !hw_q) begin
                    wr_low_q <= data_s;
                end
                if (!held_read && hw_q && !held_data) begin
                    reg_write_valid_q <= 1'b1;
                    reg_write_select_q <= sel_q;
                    reg_write_data_q <= {data_s, wr_low_q};
                end
            end
            case (state_q)
                ST_IDLE: begin
                    if (strobe_fall && cur_data && cur_read && !hw_s) begin
                        aux_request_q <= 1'b1;
                        aux_write_q <= 1'b0;
                        aux_increment_q <= 1'b0;
                        state_q <= ST_FETCH;
                    end else if (strobe_fall && cur_data && cur_read) begin
                        out_q <= word_q[`HIGH_HALF];
                        state_q <= ST_SHOW;
                    end else if (strobe_rise && held_data && hw_q && !held_read) begin
                        aux_request_q <= 1'b1;
                        aux_write_q <= 1'b1;
                        aux_increment_q <= (sel_q == `SEL_DATA_INC);
                        aux_write_data_q <= {data_s, wr_low_q};
                        state_q <= ST_STORE;
                    end else if (strobe_rise && (sel_q == `SEL_DATA_INC) && hw_q && held_read) begin
                        aux_request_q <= 1'b1;
                        aux_write_q <= 1'b0;
                        aux_increment_q <= 1'b1;
                        state_q <= ST_STORE;
                    end
                end
                ST_FETCH: begin
                    if (aux_done) begin
                        word_q <= aux_read_data;
                        out_q <= aux_read_data[`LOW_HALF];
                        state_q <= ST_SHOW;
                    end
                end
                ST_SHOW: begin
                    // Data sat on the bus for this cycle; ready follows next.
                    state_q <= ST_IDLE;
                end
                ST_STORE: begin
                    if (aux_done) begin
                        if (!aux_write_q) begin
                            word_q <= aux_read_data;
                        end
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Gated straight from the pin so the output drops without the
    // synchroniser latency; the host sees a pending busy as soon as it selects.
    wire busy;
    assign busy = (state_q != ST_IDLE) | as_busy_q;
    assign host_not_ready = ~host_chip_select_n & busy;

    assign host_data_bus_out = out_q;
    assign host_data_bus_oe = oe_q;
    assign aux_request = aux_request_q;
    assign aux_write = aux_write_q;
    assign aux_increment = aux_increment_q;
    assign aux_write_data = aux_write_data_q;
    assign reg_write_valid = reg_write_valid_q;
    assign reg_write_select = reg_write_select_q;
    assign reg_write_data = reg_write_data_q;

endmodule // host_port_strobe_ready

`default_nettype wire

// File: design/host_port_consts.vh
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH

// ****************************************************************
// Register select codes
// ****************************************************************
`define SEL_CONTROL 2'h0
`define SEL_DATA_INC 2'h1
`define SEL_ADDRESS 2'h2
`define SEL_DATA_FIXED 2'h3

// ****************************************************************
// Widths and field positions
// ****************************************************************
`define HALF_WIDTH 16
`define WORD_WIDTH 32
`define LOW_HALF 15:0
`define HIGH_HALF 31:16
`define PIN_COUNT 24

// ****************************************************************
// Read/write select level meaning a read
// ****************************************************************
`define RW_READ 1'h1

`endif

// File: design/pin_sync_agree.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Three-stage pin synchroniser
// ****************************************************************
// A bit changes only once the second and third stages agree, which
// filters a single-cycle glitch at the cost of one extra cycle.
module pin_sync_agree #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst_n,
    input wire clock_enable,
    input wire [WIDTH-1:0] pins,
    output wire [WIDTH-1:0] pins_sync
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    reg [WIDTH-1:0] out_q;
    integer i;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1_q <= {WIDTH{1'b1}};
            stage2_q <= {WIDTH{1'b1}};
            stage3_q <= {WIDTH{1'b1}};
            out_q <= {WIDTH{1'b1}};
        end else if (clock_enable) begin
            stage1_q <= pins;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2_q[i] == stage3_q[i]) begin
                    out_q[i] <= stage3_q[i];
                end
            end
        end
    end

    assign pins_sync = out_q;

endmodule // pin_sync_agree

`default_nettype wire

// File: tb/host_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    input wire logic host_chip_select_n,
    input wire logic host_data_strobe_a,
    input wire logic host_data_strobe_b,
    input wire logic host_address_strobe_n,
    input wire logic [1:0] host_register_select,
    input wire logic host_read_write,
    input wire logic host_halfword_select,
    input wire logic [15:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    input wire logic host_not_ready,
    input wire logic aux_request,
    input wire logic aux_write,
    input wire logic aux_done
);
    // Delay ranges allow for the pin filter, which holds every pin edge back by a few cycles.
    wire strobe_n = host_chip_select_n | ~(host_data_strobe_a ^ host_data_strobe_b);
    wire data_sel = host_register_select[0];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_cs_gate: assert property (host_chip_select_n |-> !host_not_ready) else $error("busy while deselected");
    a_read_fetch: assert property ($fell(strobe_n) && data_sel && host_read_write && !host_halfword_select
        |-> ##[2:7] aux_request && !aux_write && host_not_ready) else $error("no fetch on read");
    a_write_req: assert property ($rose(strobe_n) && data_sel && !host_read_write && host_halfword_select
        |-> ##[2:7] aux_request && aux_write && host_not_ready) else $error("no write request");
    a_addr_busy: assert property ($fell(host_address_strobe_n) && !host_chip_select_n && clock_enable
        |-> ##[2:7] host_not_ready) else $error("no busy on address strobe");
    a_done_clear: assert property (aux_done && host_address_strobe_n |-> ##[1:2] !host_not_ready)
        else $error("busy after completion");
    a_ready_data: assert property ($fell(host_not_ready) && host_data_bus_oe && !host_chip_select_n
        |=> $stable(host_data_bus_out)) else $error("data moved after ready");
    a_oe_release: assert property (strobe_n [*8] |-> !host_data_bus_oe) else $error("bus still driven");
    a_quiet_regs: assert property ((!data_sel && host_address_strobe_n && !host_not_ready) [*8]
        |=> !host_not_ready) else $error("busy on register access");
endmodule // host_port_checker
bind host_port_strobe_ready host_port_checker chk (.*);
`default_nettype wire

// File: tb/aux_channel_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory stand-in with one word; addresses are not modelled, so increments change nothing.
module aux_channel_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic aux_request,
    input wire logic aux_write,
    input wire logic [31:0] aux_write_data,
    input wire logic [3:0] aux_delay,
    output var logic aux_done,
    output wire logic [31:0] aux_read_data,
    output var logic [31:0] stored_word
);
    logic busy_q;
    logic [3:0] count_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {busy_q, count_q, aux_done, stored_word} <= 38'h0;
        end else begin
            aux_done <= busy_q && count_q == 4'h0;
            busy_q <= aux_request || (busy_q && count_q != 4'h0);
            count_q <= aux_request ? aux_delay : count_q - 4'h1;
            if (aux_request && aux_write) stored_word <= aux_write_data;
        end
    end
    // Outside the done pulse the lines show the inverse, so a stale sample cannot pass.
    assign aux_read_data = aux_done ? stored_word : ~stored_word;
endmodule // aux_channel_model
`default_nettype wire

// File: tb/host_port_strobe_ready_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "host_port_consts.vh"
module host_port_strobe_ready_tb;
    logic clock, rst_n, clock_enable, host_chip_select_n, host_data_strobe_a, host_data_strobe_b;
    logic host_address_strobe_n, host_read_write, host_halfword_select, host_data_bus_oe, host_not_ready;
    logic aux_request, aux_write, aux_increment, aux_done, reg_write_valid, seen_inc;
    logic [1:0] host_register_select, reg_write_select, seen_sel, sel;
    logic [3:0] aux_delay;
    logic [15:0] host_data_bus_in, host_data_bus_out, rd;
    logic [31:0] aux_write_data, aux_read_data, reg_write_data, control_read_data, address_read_data;
    logic [31:0] stored_word, seen_data, w;
    integer seed;
    int failures, checks_done, cycles, i;
    host_port_strobe_ready uut (.*);
    aux_channel_model partner (.*);
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (reg_write_valid === 1'h1) begin
            seen_sel <= reg_write_select;
            seen_data <= reg_write_data;
        end
        if (aux_request === 1'h1) begin
            seen_inc <= aux_increment;
        end
        // A full run needs about 1000 cycles, so this ceiling only trips on a hang.
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] reg_half(input logic [1:0] s, input logic half);
        logic [31:0] v;
        v = (s == `SEL_ADDRESS) ? address_read_data : control_read_data;
        return half ? v[31:16] : v[15:0];
    endfunction
    task automatic access(input logic [1:0] s, input logic rw, half, input logic [15:0] wd, input logic settle);
        @(negedge clock);
        {host_register_select, host_read_write, host_halfword_select} = {s, rw, half};
        host_data_bus_in = rw ? ~wd : wd;
        @(negedge clock);
        host_data_strobe_a = 1'h1;
        repeat (7) @(negedge clock);
        while (host_not_ready !== 1'h0) @(negedge clock);
        rd = host_data_bus_out;
        if (rw) check("bus enable", 32'h1, host_data_bus_oe);
        host_data_strobe_a = 1'h0;
        repeat (8) @(negedge clock);
        while (settle && host_not_ready !== 1'h0) @(negedge clock);
    endtask
    task automatic report_and_stop;
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        seed = 32'h24deb097;
        {clock_enable, rst_n, host_chip_select_n, host_data_strobe_a, host_data_strobe_b} = 5'h14;
        {host_address_strobe_n, host_register_select, host_read_write, host_halfword_select} = 5'h13;
        host_data_bus_in = 16'h0;
        aux_delay = 4'h0;
        control_read_data = $random(seed);
        address_read_data = $random(seed);
        repeat (20) @(negedge clock);
        check("reset outputs", 32'h0, {host_not_ready, host_data_bus_oe, aux_request});
        rst_n = 1'h1;
        repeat (4) @(negedge clock);
        host_chip_select_n = 1'h0;
        for (i = 0; i < 8; i++) begin
            w = $random(seed);
            aux_delay = (i == 0) ? 4'h0 : 4'($random(seed));
            sel = i[0] ? `SEL_DATA_INC : `SEL_DATA_FIXED;
            access(sel, 1'h0, 1'h0, w[15:0], 1'h1);
            access(sel, 1'h0, 1'h1, w[31:16], 1'h1);
            check("increment flag", sel == `SEL_DATA_INC, seen_inc);
            check("stored word", w, stored_word);
            access(sel, `RW_READ, 1'h0, 16'h0, 1'h1);
            check("read low half", w[15:0], rd);
            access(sel, `RW_READ, 1'h1, 16'h0, 1'h1);
            check("read high half", w[31:16], rd);
        end
        {host_register_select, host_read_write, host_halfword_select} = {`SEL_DATA_FIXED, `RW_READ, 1'h0};
        @(negedge clock);
        clock_enable = 1'h0;
        host_address_strobe_n = 1'h0;
        repeat (8) @(negedge clock);
        check("frozen busy", 32'h0, host_not_ready);
        clock_enable = 1'h1;
        repeat (8) @(negedge clock);
        check("busy on address strobe", 32'h1, host_not_ready);
        access(`SEL_DATA_FIXED, `RW_READ, 1'h0, 16'h0, 1'h1);
        host_address_strobe_n = 1'h1;
        check("read after address strobe", w[15:0], rd);
        aux_delay = 4'hf;
        w = $random(seed);
        access(`SEL_DATA_INC, 1'h0, 1'h0, w[15:0], 1'h1);
        access(`SEL_DATA_INC, 1'h0, 1'h1, w[31:16], 1'h0);
        host_chip_select_n = 1'h1;
        @(negedge clock);
        check("deselected busy", 32'h0, host_not_ready);
        host_chip_select_n = 1'h0;
        @(negedge clock);
        check("busy on reselect", 32'h1, host_not_ready);
        while (host_not_ready !== 1'h0) @(negedge clock);
        check("stored word after reselect", w, stored_word);
        for (i = 0; i < 4; i++) begin
            w = $random(seed);
            sel = i[0] ? `SEL_ADDRESS : `SEL_CONTROL;
            access(sel, 1'h0, 1'h0, w[15:0], 1'h1);
            access(sel, 1'h0, 1'h1, w[31:16], 1'h1);
            check("register word", w, seen_data);
            check("register select", sel, seen_sel);
            access(sel, `RW_READ, i[1], 16'h0, 1'h1);
            check("register read", reg_half(sel, i[1]), rd);
        end
        report_and_stop();
    end
endmodule // host_port_strobe_ready_tb
`default_nettype wire
